/* File: design/pmx_pkg.sv */
// package for the pin output function mux: widths, reset values and encodings
`default_nettype none
package pmx_pkg;
	// reset values of the port control bits
	localparam logic PMX_LATCH_RST = 1'h0;
	localparam logic PMX_DIR_RST = 1'h1;
	localparam logic PMX_OD_RST = 1'h0;
	localparam logic PMX_ANA_RST = 1'h0;
	localparam logic PMX_REDIR_RST = 1'h0;
	// levels used to tie off absent gate inputs
	localparam logic PMX_TIE_HIGH = 1'h1;
	localparam logic PMX_TIE_LOW = 1'h0;
	// direction bit encoding
	localparam logic PMX_DIR_OUT = 1'h0;
	localparam logic PMX_DIR_IN = 1'h1;
	// analog pin config codes
	localparam int PMX_CFG_W = 4;
	localparam logic [PMX_CFG_W-1:0] PMX_CFG_ALL_DIGITAL = 4'h1;
	localparam logic [PMX_CFG_W-1:0] PMX_CFG_RST = 4'h0;
endpackage : pmx_pkg
`default_nettype wire

/* File: design/pmx_pin_cell.sv */
// one pin output cell: and/or combining, direction and open-drain drive
`default_nettype none
module pmx_pin_cell #(
	parameter bit HAS_SERIAL = 1'h1,
	parameter bit HAS_OTHER = 1'h1,
	parameter bit HAS_OD = 1'h1,
	parameter bit HAS_ANALOG = 1'h1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// control bits
	input wire logic i_latch,
	input wire logic i_dir,
	input wire logic i_od,
	input wire logic i_analog,
	// peripheral outputs
	input wire logic i_serial_out,
	input wire logic i_other_out,
	// synchronised pin level
	input wire logic i_pin_sync,
	// pin drive
	output logic o_pin_out,
	output logic o_pin_oe,
	output logic o_read
);
	logic serial_term;
	logic other_term;
	logic od_term;
	logic data;
	logic nxt_out;
	logic nxt_oe;
	logic pin_out_ff;
	logic pin_oe_ff;
	logic read_ff;

	////////////////////////////////////////////////////////////
	// absent tie-offs
	assign serial_term = HAS_SERIAL ? i_serial_out : pmx_pkg::PMX_TIE_HIGH;
	assign other_term = HAS_OTHER ? i_other_out : pmx_pkg::PMX_TIE_LOW;
	assign od_term = HAS_OD ? i_od : pmx_pkg::PMX_TIE_LOW;
	assign data = (i_latch & serial_term) | other_term;

	// open drain only drives low; analog pins never drive
	always_comb begin
		nxt_out = data;
		nxt_oe = (i_dir == pmx_pkg::PMX_DIR_OUT) && !(HAS_ANALOG && i_analog);
		if (od_term) begin
			nxt_out = pmx_pkg::PMX_TIE_LOW;
			nxt_oe = nxt_oe && !data;
		end
	end

	// registered drive; reset leaves the pin undriven
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pin_out_ff <= pmx_pkg::PMX_TIE_LOW;
			pin_oe_ff <= pmx_pkg::PMX_TIE_LOW;
		end else begin
			pin_out_ff <= nxt_out;
			pin_oe_ff <= nxt_oe;
		end
	end

	// read-back: pin in input mode, latch in output mode
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			read_ff <= pmx_pkg::PMX_TIE_LOW;
		end else begin
			read_ff <= (i_dir == pmx_pkg::PMX_DIR_IN) ? i_pin_sync : i_latch;
		end
	end

	assign o_pin_out = pin_out_ff;
	assign o_pin_oe = pin_oe_ff;
	assign o_read = read_ff;
endmodule : pmx_pin_cell
`default_nettype wire

/* File: design/pmx_pin_mux.sv */
// pin output function mux: two pins sharing serial, timer, buzzer and i2c outputs
// Contract
// - analog pin config or analog select bit picks analog or digital use
// - port latch ANDed with serial alternate output
// - pin driven by that AND ORed with other peripheral outputs
// - pins lacking open-drain bit behave as push-pull
// - absent serial input ties high, absent other input ties low
// - redirect bit moves redirectable output to alternate pin
// - open-drain bit with output direction gives n-channel open drain
// - latch cleared on reset, holds data until next write
// - after reset every port is input, output high impedance; direction is input only during reset, then i_port_direction_bit
// - read returns pin in input mode, latch in output mode
`default_nettype none
module pmx_pin_mux #(
	parameter int CFG_W = pmx_pkg::PMX_CFG_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// port latch write, one bit per pin
	input wire logic i_latch_we,
	input wire logic [1:0] i_latch_wdata,
	// per-pin control bits
	input wire logic [1:0] i_port_direction_bit,
	input wire logic [1:0] i_port_open_drain_bit,
	input wire logic [1:0] i_port_analog_select_bit,
	input wire logic [CFG_W-1:0] i_analog_pin_config,
	input wire logic i_peripheral_redirect_bit,
	// peripheral outputs
	input wire logic i_serial_data_output,
	input wire logic i_timer_channel_output,
	input wire logic i_clock_buzzer_output,
	input wire logic i_i2c_unit_data_out,
	// pins
	input wire logic [1:0] i_pin,
	output logic [1:0] o_pin_out,
	output logic [1:0] o_pin_oe,
	// port read data and status
	output logic [1:0] o_port_read,
	output logic [1:0] o_latch,
	output logic [1:0] o_analog_mode
);
	logic [1:0] latch_ff;
	logic [1:0] pin_meta_ff;
	logic [1:0] pin_sync_ff;
	logic [1:0] analog_ff;
	logic [1:0] nxt_analog;
	logic [1:0] other_out;
	logic [1:0] dir_eff;

	////////////////////////////////////////////////////////////
	// port latch, cleared by reset, held between writes
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			latch_ff <= {2{pmx_pkg::PMX_LATCH_RST}};
		end else if (i_latch_we) begin
			latch_ff <= i_latch_wdata;
		end
	end

	// pin levels come from outside; two flops before use
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pin_meta_ff <= {2{pmx_pkg::PMX_TIE_LOW}};
			pin_sync_ff <= {2{pmx_pkg::PMX_TIE_LOW}};
		end else begin
			pin_meta_ff <= i_pin;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////
	// analog selection: pin 0 by config code, pin 1 by select bit
	always_comb begin
		nxt_analog[0] = (i_analog_pin_config != pmx_pkg::PMX_CFG_ALL_DIGITAL);
		nxt_analog[1] = i_port_analog_select_bit[1];
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			analog_ff <= {2{pmx_pkg::PMX_ANA_RST}};
		end else begin
			analog_ff <= nxt_analog;
		end
	end

	////////////////////////////////////////////////////////////
	// timer output goes to pin 0 normally, pin 1 when redirected
	always_comb begin
		other_out[0] = i_clock_buzzer_output;
		other_out[1] = i_i2c_unit_data_out;
		if (i_peripheral_redirect_bit) begin
			other_out[1] = other_out[1] | i_timer_channel_output;
		end else begin
			other_out[0] = other_out[0] | i_timer_channel_output;
		end
	end

	// direction forced to input while reset holds
	assign dir_eff = i_rst ? {2{pmx_pkg::PMX_DIR_RST}} : i_port_direction_bit;

	////////////////////////////////////////////////////////////
	// pin 0: serial output, analog capable, open drain present
	pmx_pin_cell #(
		.HAS_SERIAL(1'h1),
		.HAS_OTHER(1'h1),
		.HAS_OD(1'h1),
		.HAS_ANALOG(1'h1)
	) u_cell0 (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_latch(latch_ff[0]),
		.i_dir(dir_eff[0]),
		.i_od(i_port_open_drain_bit[0]),
		.i_analog(analog_ff[0]),
		.i_serial_out(i_serial_data_output),
		.i_other_out(other_out[0]),
		.i_pin_sync(pin_sync_ff[0]),
		.o_pin_out(o_pin_out[0]),
		.o_pin_oe(o_pin_oe[0]),
		.o_read(o_port_read[0])
	);

	// pin 1: no serial function and no open-drain bit (tied off)
	pmx_pin_cell #(
		.HAS_SERIAL(1'h0),
		.HAS_OTHER(1'h1),
		.HAS_OD(1'h0),
		.HAS_ANALOG(1'h1)
	) u_cell1 (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_latch(latch_ff[1]),
		.i_dir(dir_eff[1]),
		.i_od(i_port_open_drain_bit[1]),
		.i_analog(analog_ff[1]),
		.i_serial_out(i_serial_data_output),
		.i_other_out(other_out[1]),
		.i_pin_sync(pin_sync_ff[1]),
		.o_pin_out(o_pin_out[1]),
		.o_pin_oe(o_pin_oe[1]),
		.o_read(o_port_read[1])
	);

	assign o_latch = latch_ff;
	assign o_analog_mode = analog_ff;

	////////////////////////////////////////////////////////////
	// chk_latch_reset_clear
	chk_latch_reset_clear: assert property (@(posedge i_clk) i_rst |=> latch_ff == 2'h0)
		else $error("latch not cleared by reset");
	// chk_latch_hold_value
	chk_latch_hold_value: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_latch_we |=> $stable(latch_ff)) else $error("latch changed without write");
	// chk_reset_hiz_out
	chk_reset_hiz_out: assert property (@(posedge i_clk) i_rst |=> o_pin_oe == 2'h0)
		else $error("pin driven after reset");
	// chk_input_no_drive
	chk_input_no_drive: assert property (@(posedge i_clk) disable iff (i_rst)
		i_port_direction_bit[1] |=> !o_pin_oe[1]) else $error("input pin driven");
	// chk_and_or_path
	chk_and_or_path: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_port_direction_bit[0] && !i_port_open_drain_bit[0] && !nxt_analog[0] && !analog_ff[0]
		&& !other_out[0]) |=> o_pin_out[0] == $past(latch_ff[0] & i_serial_data_output))
		else $error("latch and serial term wrong");
	// chk_other_or_term
	chk_other_or_term: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_port_direction_bit[0] && !i_port_open_drain_bit[0] && other_out[0]) |=> o_pin_out[0])
		else $error("or term not driving high");
	// chk_od_never_high
	chk_od_never_high: assert property (@(posedge i_clk) disable iff (i_rst)
		i_port_open_drain_bit[0] |=> !(o_pin_oe[0] && o_pin_out[0])) else $error("open drain drove high");
	// chk_pin1_tied_off
	chk_pin1_tied_off: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_port_direction_bit[1] && !analog_ff[1] && !i_port_analog_select_bit[1]) |=>
		o_pin_out[1] == $past(latch_ff[1] | other_out[1])) else $error("pin 1 tie-off wrong");
	// chk_redirect_timer
	chk_redirect_timer: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_peripheral_redirect_bit && i_timer_channel_output) |-> other_out[1] && (other_out[0] ==
		i_clock_buzzer_output)) else $error("redirect failed");
	// chk_read_in_mode
	chk_read_in_mode: assert property (@(posedge i_clk) disable iff (i_rst)
		i_port_direction_bit[0] |=> o_port_read[0] == $past(pin_sync_ff[0])) else $error("read not pin");
	// chk_analog_no_drive
	chk_analog_no_drive: assert property (@(posedge i_clk) disable iff (i_rst)
		analog_ff[1] |=> !o_pin_oe[1]) else $error("analog pin driven");

	////////////////////////////////////////////////////////////
	// a reset pulse followed by the first free edge
	sequence rst_release_seq;
		i_rst ##1 !i_rst;
	endsequence

	// pin 0 in open-drain output mode with low data: the cell must sink
	sequence od_low_req_seq;
		!i_port_direction_bit[0] && i_port_open_drain_bit[0] && !analog_ff[0] && !other_out[0]
			&& !(latch_ff[0] & i_serial_data_output);
	endsequence

	chk_release_hiz: assert property (@(posedge i_clk)
		rst_release_seq |-> (o_pin_oe == 2'h0) && (latch_ff == 2'h0))
		else $error("pins not idle after reset release");
	chk_od_pulls_low: assert property (@(posedge i_clk) disable iff (i_rst)
		od_low_req_seq |=> o_pin_oe[0] && !o_pin_out[0])
		else $error("open drain did not pull low");
	chk_pin1_push_pull: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_port_direction_bit[1] && !analog_ff[1]) |=> o_pin_oe[1])
		else $error("pin 1 released in output mode");
	chk_read_out_mode: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_port_direction_bit[0] |=> o_port_read[0] == $past(latch_ff[0]))
		else $error("read not latch");
	chk_analog0_no_drive: assert property (@(posedge i_clk) disable iff (i_rst)
		analog_ff[0] |=> !o_pin_oe[0])
		else $error("analog pin 0 driven");
	chk_cfg_digital: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_analog_pin_config == pmx_pkg::PMX_CFG_ALL_DIGITAL) |=> !analog_ff[0])
		else $error("pin 0 analog under digital code");
endmodule : pmx_pin_mux
`default_nettype wire

/* File: bench/pmx_pin_world.sv */
// far-side pin model: external pull or driver level unless the block drives the pin
`default_nettype none
module pmx_pin_world (
	// block pin drive
	input wire logic [1:0] i_pin_out,
	input wire logic [1:0] i_pin_oe,
	// level of the external pull-up or driver
	input wire logic [1:0] i_ext,
	// resolved pin levels
	output logic [1:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// driven pin wins, a released pin shows the external level
	assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule : pmx_pin_world
`default_nettype wire

/* File: bench/pmx_pin_mux_bench.sv */
// self-checking bench for the pin output function mux
`default_nettype none
module pmx_pin_mux_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'h0;
	logic i_rst = 1'h1;
	logic we = 1'h0;
	logic [1:0] wd = 2'h0, dir = 2'h3, od = 2'h0, asel = 2'h0, ext = 2'h3;
	logic [1:0] pin, p_out, p_oe, rd, lat, ana, d, e_out, e_oe;
	logic [3:0] cfg = 4'h1;
	// unused peripherals start at their idle levels
	logic redir = 1'h0, ser = 1'h1, tmr = 1'h0, buz = 1'h0, i2c = 1'h0;
	int n_mismatch = 0, n_compared = 0, cyc = 0;
	////////////////////////////////////////////////////////////////
	always #25 i_clk = ~i_clk;
	// run ceiling: about 960 cycles expected, cut a hang well after that
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	pmx_pin_mux i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_latch_we(we), .i_latch_wdata(wd),
		.i_port_direction_bit(dir), .i_port_open_drain_bit(od), .i_port_analog_select_bit(asel),
		.i_analog_pin_config(cfg), .i_peripheral_redirect_bit(redir), .i_serial_data_output(ser),
		.i_timer_channel_output(tmr), .i_clock_buzzer_output(buz), .i_i2c_unit_data_out(i2c),
		.i_pin(pin), .o_pin_out(p_out), .o_pin_oe(p_oe), .o_port_read(rd), .o_latch(lat),
		.o_analog_mode(ana));
	pmx_pin_world i_world (.i_pin_out(p_out), .i_pin_oe(p_oe), .i_ext(ext), .o_pin(pin));
	////////////////////////////////////////////////////////////////
	// wait whole cycles, then sample mid-period where outputs are settled
	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
		@(negedge i_clk);
	endtask : settle
	task automatic write_latch(input logic [1:0] v);
		@(posedge i_clk);
		we <= 1'h1;
		wd <= v;
		@(posedge i_clk);
		we <= 1'h0;
	endtask : write_latch
	task automatic compare(input logic [1:0] got, input logic [1:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask : compare
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'h0;
		settle(1);
		compare(p_oe, 2'h0, "enable after reset");
		compare(lat, 2'h0, "latch after reset");
		$display("test reset done");
		// every mix of latch, serial, buzzer, timer, i2c, redirect and open drain
		for (int k = 0; k < 128; k++) begin
			write_latch({~k[0], k[0]});
			@(posedge i_clk);
			dir <= 2'h0;
			{od, redir, i2c, tmr, buz, ser} <= {k[6], k[6], k[5:1]};
			settle(4);
			d[0] = (k[0] & k[1]) | k[2] | (k[3] & ~k[5]);
			d[1] = ~k[0] | k[4] | (k[3] & k[5]);
			e_oe = {1'h1, k[6] ? ~d[0] : 1'h1};
			e_out = {d[1], d[0] & ~k[6]};
			compare(p_oe, e_oe, "drive enable");
			compare(p_out, e_out, "pin data");
			compare(rd, {~k[0], k[0]}, "read in output mode");
		end
		$display("test combine done");
		// input mode: buffer off, read shows the pin, latch untouched
		@(posedge i_clk);
		{dir, od, ext} <= {2'h3, 2'h0, 2'h2};
		settle(5);
		compare(p_oe, 2'h0, "input enable");
		compare(rd, 2'h2, "read pin");
		compare(lat, 2'h1, "latch kept");
		@(posedge i_clk);
		ext <= 2'h1;
		settle(5);
		compare(rd, 2'h1, "read pin again");
		$display("test input done");
		// analog selection by config code on pin 0 and select bit on pin 1
		@(posedge i_clk);
		{dir, cfg, asel} <= {2'h0, 4'h0, 2'h2};
		settle(5);
		compare(ana, 2'h3, "analog mode");
		compare(p_oe, 2'h0, "analog enable");
		@(posedge i_clk);
		{cfg, asel} <= {4'h1, 2'h1};
		settle(5);
		compare(ana, 2'h0, "digital mode");
		compare(p_oe, 2'h3, "digital enable");
		$display("test analog done");
		// a second reset in mid-run clears the latch
		write_latch(2'h3);
		@(posedge i_clk);
		{dir, i_rst} <= {2'h3, 1'h1};
		settle(2);
		compare(lat, 2'h0, "latch cleared");
		compare(p_oe, 2'h0, "enable in reset");
		compare(rd, 2'h0, "read in reset");
		$display("test rereset done");
		// release again with the other functions idle, then serial use with latch 1
		@(posedge i_clk);
		{i_rst, redir, i2c, tmr, buz, ser} <= {1'h0, 5'h01};
		settle(1);
		compare(p_oe, 2'h0, "enable after rerelease");
		compare(lat, 2'h0, "latch after rerelease");
		write_latch(2'h1);
		@(posedge i_clk);
		{dir, ser} <= {2'h0, 1'h0};
		settle(2);
		compare(p_out, 2'h0, "serial low");
		compare(p_oe, 2'h3, "serial use enable");
		@(posedge i_clk);
		ser <= 1'h1;
		settle(2);
		compare(p_out, 2'h1, "serial high");
		// non-serial use: latch 0, serial idle high, buzzer drives pin 0
		write_latch(2'h0);
		@(posedge i_clk);
		buz <= 1'h1;
		settle(2);
		compare(p_out, 2'h1, "buzzer high");
		compare(p_oe, 2'h3, "buzzer use enable");
		$display("test use done");
		tally_and_finish();
	end
endmodule : pmx_pin_mux_bench
`default_nettype wire
